// >>> hw/cswfm_pkg.sv
package cswfm_pkg;
    // register addresses and bit layout
    localparam logic [1:0] CSWFM_ADDR_OSC_CTRL = 2'h0;
    localparam logic [1:0] CSWFM_ADDR_IRQ_FLAGS = 2'h1;
    localparam logic [1:0] CSWFM_ADDR_IRQ_ENABLES = 2'h2;
    localparam logic [1:0] CSWFM_ADDR_CONFIG = 2'h3;
    localparam int CSWFM_SCS_BIT = 0;
    localparam int CSWFM_LTS_BIT = 1;
    localparam int CSWFM_HTS_BIT = 2;
    localparam int CSWFM_STARTUP_TIMEOUT_STATUS_BIT = 3;
    localparam int CSWFM_IRCF_LSB = 4;
    localparam int CSWFM_OSF_BIT = 7;
    localparam logic [2:0] CSWFM_IRCF_RESET = 3'h6;
    localparam logic [2:0] CSWFM_IRCF_LF = 3'h0;
    // primary oscillator modes
    localparam logic [2:0] CSWFM_MODE_LP = 3'h0;
    localparam logic [2:0] CSWFM_MODE_XT = 3'h1;
    localparam logic [2:0] CSWFM_MODE_HS = 3'h2;
    localparam logic [2:0] CSWFM_MODE_EC = 3'h3;
    localparam int CSWFM_OST_COUNT = 1024;
    localparam logic [10:0] CSWFM_OST_LAST = 11'h3FF;
    localparam logic [5:0] CSWFM_FAIL_SAFE_MONITOR_DIV_LAST = 6'h1F;
    typedef enum logic [1:0] {
        CSWFM_SRC_PRIMARY,
        CSWFM_SRC_INTERNAL,
        CSWFM_SRC_HOLD
    } cswfm_src_t;
    typedef struct packed {
        logic [2:0] primary_osc_config;
        logic two_speed_enable;
        logic fail_monitor_enable;
    } cswfm_cfg_t;
endpackage : cswfm_pkg

// >>> hw/cswfm_clock_switch.sv
// What this block does
// - select 0 runs from configured primary
// - select 1 runs from internal oscillator
// - every reset clears select bit
// - automatic switches leave select bit alone
// - timeout status shows external source running
// - crystal modes wait 1024 oscillations
// - sleep aborts count, status stays clear
// - two-speed needs enable, select 0, crystal
// - two-speed entered after reset and wake
// - non-crystal modes disable two-speed start
// - timeout, internal fall, status, external fall
// - monitor enabled by config, all external modes
// - sample clock is low osc over 64
// - latch set by fall, cleared by sample
// - failure switches internal, sets fail flag
// - fail flag with enable raises interrupt
// - after failure run chosen internal frequency
// - reset, sleep, select toggle clear failure
// - select toggle restarts timer, then external if select 0
// - flag clear ignored while failure present
// - monitor idle while start-up timer runs
// - monitor enable also enables two-speed
// - reset loads frequency select with 110
// - internal switch: old fall, new rise
//
// Implementation choices: the address map and the Avalon-MM slave port.
`timescale 1ns/1ps
`default_nettype none
module cswfm_clock_switch
    import cswfm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire cswfm_cfg_t cfg_in,
    input wire logic primary_osc_in,
    input wire logic int_osc_in,
    input wire logic lf_osc_in,
    input wire logic powerup_timer_done_in,
    input wire logic sleep_in,
    input wire logic wake_in,
    input wire logic [1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    output logic [31:0] avs_readdata_out,
    output logic avs_waitrequest_out,
    output logic sys_clk_out,
    output logic exec_hold_out,
    output logic irq_out
);
    logic [2:0] prim_s1_r, prim_s2_r, prim_d_r;
    logic scs_r;
    logic [2:0] ircf_r;
    logic [2:0] ircf_cur_r;
    logic startup_timeout_status_r;
    logic osf_flag_r;
    logic osf_en_r;
    logic fail_r;
    logic ost_run_r;
    logic [10:0] ost_cnt_r;
    logic ost_wait_int_r;
    logic ost_wait_ext_r;
    logic [5:0] div_cnt_r;
    logic sample_clk_r;
    logic det_latch_r;
    logic started_r;
    logic ack_r;
    logic int_sw_r;
    cswfm_src_t src_r;
    logic prim_fall, prim_rise, int_fall, int_rise, lf_rise;
    logic crystal, two_speed, fsc_active, restart, toggle_scs;
    logic wr_osc, wr_flags, wr_en, sel_int;

    function automatic logic is_crystal(input logic [2:0] m);
        is_crystal = (m == CSWFM_MODE_LP) || (m == CSWFM_MODE_XT) ||
            (m == CSWFM_MODE_HS);
    endfunction : is_crystal

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            prim_s1_r <= 3'h0;
            prim_s2_r <= 3'h0;
            prim_d_r <= 3'h0;
        end else if (clk_en_in) begin
            prim_s1_r <= {lf_osc_in, int_osc_in, primary_osc_in};
            prim_s2_r <= prim_s1_r;
            prim_d_r <= prim_s2_r;
        end
    end

    // synchronised edges of the three clocks
    assign prim_fall = prim_d_r[0] & ~prim_s2_r[0];
    assign prim_rise = ~prim_d_r[0] & prim_s2_r[0];
    assign int_fall = prim_d_r[1] & ~prim_s2_r[1];
    assign int_rise = ~prim_d_r[1] & prim_s2_r[1];
    assign lf_rise = ~prim_d_r[2] & prim_s2_r[2];

    assign crystal = is_crystal(cfg_in.primary_osc_config);
    assign two_speed = (cfg_in.two_speed_enable | cfg_in.fail_monitor_enable)
        & ~scs_r & crystal;
    assign wr_osc = avs_write_in && avs_address_in == CSWFM_ADDR_OSC_CTRL;
    assign wr_flags = avs_write_in && avs_address_in == CSWFM_ADDR_IRQ_FLAGS;
    assign wr_en = avs_write_in && avs_address_in == CSWFM_ADDR_IRQ_ENABLES;
    assign toggle_scs = wr_osc && ack_r &&
        (avs_writedata_in[CSWFM_SCS_BIT] != scs_r);
    assign restart = wake_in | toggle_scs | (~started_r & powerup_timer_done_in);

    // registered answer after one wait cycle
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ack_r <= 1'b0;
        end else if (clk_en_in) begin
            ack_r <= (avs_read_in | avs_write_in) & ~ack_r;
        end
    end
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            scs_r <= 1'b0;
            ircf_r <= CSWFM_IRCF_RESET;
            osf_en_r <= 1'b0;
        end else if (clk_en_in && wr_osc && ack_r) begin
            scs_r <= avs_writedata_in[CSWFM_SCS_BIT];
            ircf_r <= avs_writedata_in[CSWFM_IRCF_LSB +: 3];
        end else if (clk_en_in && wr_en && ack_r) begin
            osf_en_r <= avs_writedata_in[CSWFM_OSF_BIT];
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            started_r <= 1'b0;
        end else if (clk_en_in && powerup_timer_done_in) begin
            started_r <= 1'b1;
        end
    end

    // start-up timer counted on external falling edges
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ost_run_r <= 1'b0;
            ost_cnt_r <= 11'h000;
            ost_wait_int_r <= 1'b0;
            ost_wait_ext_r <= 1'b0;
            startup_timeout_status_r <= 1'b0;
        end else if (clk_en_in) begin
            if (sleep_in) begin
                ost_run_r <= 1'b0;
                ost_wait_int_r <= 1'b0;
                ost_wait_ext_r <= 1'b0;
                startup_timeout_status_r <= 1'b0;
            end else if (restart) begin
                ost_cnt_r <= 11'h000;
                ost_run_r <= crystal | toggle_scs;
                ost_wait_int_r <= 1'b0;
                ost_wait_ext_r <= 1'b0;
                startup_timeout_status_r <= ~crystal & ~toggle_scs & ~scs_r;
            end else if (ost_run_r && prim_fall) begin
                if (ost_cnt_r[9:0] == CSWFM_OST_LAST[9:0]) begin
                    ost_run_r <= 1'b0;
                    ost_wait_int_r <= 1'b1;
                end
                ost_cnt_r <= ost_cnt_r + 11'h001;
            end else if (ost_wait_int_r && int_fall) begin
                ost_wait_int_r <= 1'b0;
                ost_wait_ext_r <= 1'b1;
                startup_timeout_status_r <= 1'b1;
            end else if (ost_wait_ext_r && prim_fall) begin
                ost_wait_ext_r <= 1'b0;
            end else if (fail_r) begin
                startup_timeout_status_r <= 1'b0;
            end
        end
    end

    // sample clock: low oscillator over 64
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            div_cnt_r <= 6'h00;
            sample_clk_r <= 1'b0;
        end else if (clk_en_in && lf_rise) begin
            if (div_cnt_r == CSWFM_FAIL_SAFE_MONITOR_DIV_LAST) begin
                div_cnt_r <= 6'h00;
                sample_clk_r <= ~sample_clk_r;
            end else begin
                div_cnt_r <= div_cnt_r + 6'h01;
            end
        end
    end

    assign fsc_active = cfg_in.fail_monitor_enable & ~ost_run_r &
        ~ost_wait_int_r & ~ost_wait_ext_r & ~scs_r;

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            det_latch_r <= 1'b1;
            fail_r <= 1'b0;
        end else if (clk_en_in) begin
            if (sleep_in || toggle_scs) begin
                fail_r <= 1'b0;
                det_latch_r <= 1'b1;
            end else if (prim_fall) begin
                det_latch_r <= 1'b1;
            end else if (lf_rise && div_cnt_r == CSWFM_FAIL_SAFE_MONITOR_DIV_LAST
                && !sample_clk_r) begin
                if (!det_latch_r && fsc_active) begin
                    fail_r <= 1'b1;
                end
                det_latch_r <= 1'b0;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            osf_flag_r <= 1'b0;
        end else if (clk_en_in) begin
            if (fail_r) begin
                osf_flag_r <= 1'b1;
            end else if (wr_flags && ack_r) begin
                osf_flag_r <= avs_writedata_in[CSWFM_OSF_BIT];
            end
        end
    end
    assign irq_out = osf_flag_r & osf_en_r;

    assign sel_int = scs_r | fail_r | ost_run_r | ost_wait_int_r;

    // internal frequency switch: old fall, hold, new rise
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            ircf_cur_r <= CSWFM_IRCF_RESET;
            int_sw_r <= 1'b0;
        end else if (clk_en_in) begin
            if (!int_sw_r && ircf_r != ircf_cur_r && int_fall) begin
                int_sw_r <= 1'b1;
            end else if (int_sw_r && int_rise) begin
                int_sw_r <= 1'b0;
                ircf_cur_r <= ircf_r;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            src_r <= CSWFM_SRC_INTERNAL;
        end else if (clk_en_in) begin
            if (ost_wait_ext_r || int_sw_r) begin
                src_r <= CSWFM_SRC_HOLD;
            end else if (sel_int) begin
                src_r <= CSWFM_SRC_INTERNAL;
            end else begin
                src_r <= CSWFM_SRC_PRIMARY;
            end
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sys_clk_out <= 1'b0;
            exec_hold_out <= 1'b1;
        end else if (clk_en_in) begin
            case (src_r)
                CSWFM_SRC_PRIMARY: sys_clk_out <= prim_s2_r[0];
                CSWFM_SRC_INTERNAL: sys_clk_out <= prim_s2_r[1];
                default: sys_clk_out <= 1'b0;
            endcase
            // no two-speed: execution waits for timer
            exec_hold_out <= ost_run_r & ~two_speed & ~scs_r;
        end
    end

    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
        end else if (clk_en_in) begin
            avs_readdata_out <= 32'h0000_0000;
            if (avs_address_in == CSWFM_ADDR_OSC_CTRL) begin
                avs_readdata_out[CSWFM_SCS_BIT] <= scs_r;
                avs_readdata_out[CSWFM_LTS_BIT] <= ircf_cur_r == CSWFM_IRCF_LF;
                avs_readdata_out[CSWFM_HTS_BIT] <= ircf_cur_r != CSWFM_IRCF_LF;
                avs_readdata_out[CSWFM_STARTUP_TIMEOUT_STATUS_BIT] <= startup_timeout_status_r;
                avs_readdata_out[CSWFM_IRCF_LSB +: 3] <= ircf_r;
            end else if (avs_address_in == CSWFM_ADDR_IRQ_FLAGS) begin
                avs_readdata_out[CSWFM_OSF_BIT] <= osf_flag_r;
            end else if (avs_address_in == CSWFM_ADDR_IRQ_ENABLES) begin
                avs_readdata_out[CSWFM_OSF_BIT] <= osf_en_r;
            end else begin
                avs_readdata_out[4:0] <= cfg_in;
            end
        end
    end
endmodule : cswfm_clock_switch
`default_nettype wire

// >>> testbench/cswfm_xtal_model.sv
`timescale 1ns/1ps
`default_nettype none
module cswfm_xtal_model #(
    parameter int HALF_NS = 20
) (
    input wire logic run_in,
    output logic osc_out
);
    // a failed crystal stalls at its last level
    initial osc_out = 1'b0;
    always begin
        #(HALF_NS);
        if (run_in) osc_out = !osc_out;
    end
endmodule : cswfm_xtal_model
`default_nettype wire

// >>> testbench/cswfm_clock_switch_sva.sv
`timescale 1ns/1ps
`default_nettype none
module cswfm_clock_switch_sva
    import cswfm_pkg::*;
(
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    input wire logic clk_en_in,
    input wire cswfm_cfg_t cfg_in,
    input wire logic wake_in,
    input wire logic [1:0] avs_address_in,
    input wire logic avs_read_in,
    input wire logic avs_write_in,
    input wire logic [31:0] avs_writedata_in,
    input wire logic [31:0] avs_readdata_out,
    input wire logic avs_waitrequest_out,
    input wire logic sys_clk_out,
    input wire logic exec_hold_out,
    input wire logic irq_out
);
    default clocking @(posedge ref_clk_in); endclocking
    default disable iff (!rst_n_in);
    logic tk, rd0, wr0, sel_r;
    logic [2:0] frq_r;
    logic [11:0] since_r;
    assign tk = !avs_waitrequest_out;
    assign rd0 = avs_read_in && tk && avs_address_in == CSWFM_ADDR_OSC_CTRL;
    assign wr0 = avs_write_in && tk && avs_address_in == CSWFM_ADDR_OSC_CTRL;
    // software view of select and frequency
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            sel_r <= 1'b0;
            frq_r <= CSWFM_IRCF_RESET;
        end else if (wr0) begin
            sel_r <= avs_writedata_in[CSWFM_SCS_BIT];
            frq_r <= avs_writedata_in[CSWFM_IRCF_LSB+:3];
        end
    end
    // cycles since reset or wake
    always_ff @(posedge ref_clk_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            since_r <= 12'h0;
        end else begin
            since_r <= wake_in ? 12'h0 : since_r + {11'h0, since_r != 12'hFFF};
        end
    end
    chk_wait_first: assert property (
        $rose(avs_read_in) || $rose(avs_write_in) |-> avs_waitrequest_out)
        else $error("no wait cycle");
    chk_wait_one: assert property (clk_en_in && avs_waitrequest_out &&
        (avs_read_in || avs_write_in) |=> !avs_waitrequest_out)
        else $error("wait too long");
    chk_sel_track: assert property (rd0 |->
        avs_readdata_out[CSWFM_SCS_BIT] == sel_r) else $error("select moved");
    chk_freq_track: assert property (rd0 |->
        avs_readdata_out[CSWFM_IRCF_LSB+:3] == frq_r) else $error("freq bad");
    chk_cfg_read: assert property (avs_read_in && tk &&
        avs_address_in == CSWFM_ADDR_CONFIG |-> avs_readdata_out[4:0] == cfg_in)
        else $error("config readback");
    chk_irq_off: assert property (avs_write_in && tk &&
        avs_address_in == CSWFM_ADDR_IRQ_ENABLES &&
        !avs_writedata_in[CSWFM_OSF_BIT] |=> !irq_out) else $error("irq on");
    chk_reset_outs: assert property ($rose(rst_n_in) |->
        exec_hold_out && !irq_out && !sys_clk_out) else $error("reset outs");
    chk_clk_freeze: assert property (!clk_en_in |=>
        $stable(sys_clk_out) && $stable(exec_hold_out)) else $error("moved");
    chk_start_clear: assert property (rd0 && since_r < 12'h7D0 &&
        cfg_in.primary_osc_config < CSWFM_MODE_EC &&
        (cfg_in.two_speed_enable || cfg_in.fail_monitor_enable)
        |-> !avs_readdata_out[CSWFM_STARTUP_TIMEOUT_STATUS_BIT]) else $error("status early");
endmodule : cswfm_clock_switch_sva
bind cswfm_clock_switch cswfm_clock_switch_sva cswfm_clock_switch_sva_i (.*);
`default_nettype wire

// >>> testbench/tb_cswfm_clock_switch.sv
`timescale 1ns/1ps
`default_nettype none
module tb_cswfm_clock_switch;
    import cswfm_pkg::*;
    logic ref_clk = 1'b0, rst_n = 1'b0, clk_en = 1'b1, run = 1'b1;
    logic int_osc = 1'b0, lf_osc = 1'b0, pwr_done = 1'b0;
    logic sleep = 1'b0, wake = 1'b0, rd = 1'b0, wr = 1'b0;
    logic [1:0] adr = 2'h0;
    logic [31:0] wdat = 32'h0, rdat;
    logic wreq, sclk, hold, irq, prim;
    cswfm_cfg_t cfg = '0;
    logic [31:0] exp_q[$], msk_q[$];
    int n_errors = 0, tests_run = 0;
    always #2.5 ref_clk = !ref_clk;
    always #7 int_osc = !int_osc;
    always #40 lf_osc = !lf_osc;
    cswfm_xtal_model cswfm_xtal_model_i (.run_in(run), .osc_out(prim));
    cswfm_clock_switch cswfm_clock_switch_i (.ref_clk_in(ref_clk),
        .rst_n_in(rst_n), .clk_en_in(clk_en), .cfg_in(cfg),
        .primary_osc_in(prim), .int_osc_in(int_osc), .lf_osc_in(lf_osc),
        .powerup_timer_done_in(pwr_done), .sleep_in(sleep), .wake_in(wake),
        .avs_address_in(adr), .avs_read_in(rd), .avs_write_in(wr),
        .avs_writedata_in(wdat), .avs_readdata_out(rdat),
        .avs_waitrequest_out(wreq), .sys_clk_out(sclk),
        .exec_hold_out(hold), .irq_out(irq));
    task automatic finish_test;
        if (n_errors == 0 && tests_run > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask : finish_test
    task automatic chk(input string nm, input logic [31:0] seen, exp);
        tests_run++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task automatic cyc(input int n);
        repeat (n) @(posedge ref_clk);
    endtask : cyc
    task automatic bus(input logic w, input logic [1:0] a,
                       input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        adr <= a;
        wdat <= d;
        rd <= !w;
        wr <= w;
        // look mid-cycle, then finish at the edge that takes it
        do begin
            @(negedge ref_clk);
            k++;
        end while (wreq !== 1'b0 && k < 50);
        if (k >= 50) chk("waitrequest", 32'h1, 32'h0);
        @(posedge ref_clk);
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : bus
    task automatic rdx(input logic [1:0] a, input logic [31:0] e, m);
        exp_q.push_back(e);
        msk_q.push_back(m);
        bus(1'b0, a, 32'h0);
    endtask : rdx
    task automatic pulse(input logic s);
        @(posedge ref_clk);
        sleep <= s;
        wake <= !s;
        @(posedge ref_clk);
        sleep <= 1'b0;
        wake <= 1'b0;
    endtask : pulse
    task automatic restart(input cswfm_cfg_t c);
        @(posedge ref_clk);
        rst_n <= 1'b0;
        pwr_done <= 1'b0;
        cfg <= c;
        cyc(6);
        rst_n <= 1'b1;
        cyc(4);
        pwr_done <= 1'b1;
    endtask : restart
    // read results, oldest note first
    always @(negedge ref_clk) begin
        if (rd && wreq === 1'b0 && exp_q.size() > 0) begin
            chk("readdata", rdat & msk_q.pop_front(), exp_q.pop_front());
        end
    end
    initial begin
        #400000;
        n_errors++;
        finish_test();
    end
    initial begin
        logic [2:0] r;
        void'($urandom(32'h29A10857));
        restart('{CSWFM_MODE_XT, 1'b0, 1'b0});
        cyc(500);
        chk("hold", hold, 32'h1);
        clk_en <= 1'b0;
        cyc(8);
        clk_en <= 1'b1;
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h60, 32'h79);
        cyc(9000);
        chk("hold", hold, 32'h0);
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h68, 32'h79);
        // monitor on, two-speed off in config
        restart('{CSWFM_MODE_XT, 1'b0, 1'b1});
        cyc(200);
        chk("hold", hold, 32'h0);
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h60, 32'h79);
        rdx(CSWFM_ADDR_CONFIG, {27'h0, cfg}, 32'h1F);
        cyc(9000);
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h68, 32'h79);
        run <= 1'b0;
        cyc(3000);
        rdx(CSWFM_ADDR_IRQ_FLAGS, 32'h80, 32'h80);
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h0, 32'h9);
        chk("irq", irq, 32'h0);
        bus(1'b1, CSWFM_ADDR_IRQ_ENABLES, 32'h80);
        cyc(2);
        chk("irq", irq, 32'h1);
        bus(1'b1, CSWFM_ADDR_IRQ_FLAGS, 32'h0);
        rdx(CSWFM_ADDR_IRQ_FLAGS, 32'h80, 32'h80);
        run <= 1'b1;
        bus(1'b1, CSWFM_ADDR_OSC_CTRL, 32'h61);
        bus(1'b1, CSWFM_ADDR_OSC_CTRL, 32'h60);
        cyc(200);
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h60, 32'h79);
        cyc(9000);
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h68, 32'h79);
        bus(1'b1, CSWFM_ADDR_IRQ_FLAGS, 32'h0);
        rdx(CSWFM_ADDR_IRQ_FLAGS, 32'h0, 32'h80);
        chk("irq", irq, 32'h0);
        for (int i = 1; i < 5; i++) begin
            r = 3'($urandom());
            bus(1'b1, CSWFM_ADDR_OSC_CTRL, {25'h0, r, 3'h0, i[0]});
            rdx(CSWFM_ADDR_OSC_CTRL, {25'h0, r, 3'h0, i[0]}, 32'h79);
        end
        bus(1'b1, CSWFM_ADDR_OSC_CTRL, 32'h60);
        // sleep twice in mid-count: count starts over
        pulse(1'b1);
        cyc(20);
        pulse(1'b0);
        cyc(5000);
        pulse(1'b1);
        cyc(20);
        pulse(1'b0);
        cyc(5000);
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h60, 32'h79);
        cyc(4500);
        rdx(CSWFM_ADDR_OSC_CTRL, 32'h68, 32'h79);
        restart('{CSWFM_MODE_EC, 1'b0, 1'b1});
        cyc(100);
        chk("hold", hold, 32'h0);
        run <= 1'b0;
        cyc(3000);
        rdx(CSWFM_ADDR_IRQ_FLAGS, 32'h80, 32'h80);
        bus(1'b1, CSWFM_ADDR_IRQ_ENABLES, 32'h80);
        cyc(2);
        chk("irq", irq, 32'h1);
        bus(1'b1, CSWFM_ADDR_IRQ_ENABLES, 32'h0);
        cyc(2);
        chk("irq", irq, 32'h0);
        cyc(4);
        finish_test();
    end
endmodule : tb_cswfm_clock_switch
`default_nettype wire
